//--- verilog/timer8_pkg.sv
// Contract
// - Count and both compares are 8-bit, compared continuously
// - Timer tick from prescaler or external pin
// - Clock select zero stops counter, CPU access stays
// - Tick clears, increments or decrements; flags top/bottom
// - CPU count write beats clear and count
// - Wave mode is three bits across two controls
// - Overflow flag per mode, can request interrupt
// - Compare flag sets on tick after equality
// - Flags visible and individually masked into requests
// - Flag cleared by service or write one
// - Compare buffered in PWM modes only
// - Buffer loads active compare at top only
// - CPU reaches buffer or active compare per mode
// - Force strobe acts like match, non-PWM only
// - Count write blocks matches on next tick
// - Output state survives wave mode changes
// - Output action unbuffered, applies at next match
// - Reset clears output state to zero
// - Nonzero action overrides port; direction from port
// - Action zero leaves output state unchanged
// - Bottom 0x00, max 0xff, top max or compare A
// - Select 7 rising, 6 falling synchronised pin edges
// - Normal mode overflow sets as counter wraps
`default_nettype none
package timer8_pkg;
  // ==========================================================
  // Bus carriers
  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } axil_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axil_resp_t;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_CONTROL_A = 8'h00;
  localparam logic [7:0] OFF_CONTROL_B = 8'h04;
  localparam logic [7:0] OFF_COUNT     = 8'h08;
  localparam logic [7:0] OFF_COMPARE_A = 8'h0c;
  localparam logic [7:0] OFF_COMPARE_B = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h14;
  localparam logic [7:0] OFF_IRQ_FLAG  = 8'h18;
  // ==========================================================
  // Field positions and reset values
  localparam int CA_ACT_A_LSB = 6;
  localparam int CA_ACT_B_LSB = 4;
  localparam int CB_FORCE_A   = 7;
  localparam int CB_FORCE_B   = 6;
  localparam int CB_WAVE2     = 3;
  localparam int IRQ_OV       = 0;
  localparam int IRQ_A        = 1;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ==========================================================
  // Counter limits, clock selects, modes, actions
  localparam logic [7:0] BOTTOM_VAL  = 8'h00;
  localparam logic [7:0] MAX_VAL     = 8'hff;
  localparam logic [9:0] PRE_MASK_8    = 10'h007;
  localparam logic [9:0] PRE_MASK_64   = 10'h03f;
  localparam logic [9:0] PRE_MASK_256  = 10'h0ff;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3ff;
  localparam logic [2:0] WM_NORMAL = 3'h0;
  localparam logic [2:0] WM_CTC    = 3'h2;
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
endpackage : timer8_pkg
`default_nettype wire

//--- verilog/timer8_unit.sv
// The address map and register access over AXI4-Lite were chosen for this implementation.
`default_nettype none
module timer8_unit
  import timer8_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  // Register bus
  input  wire axil_req_t  i_bus,
  output var  axil_resp_t o_bus,
  // Pins and port
  input  wire logic       i_ext_count_pin,
  input  wire logic [1:0] i_port_out,
  input  wire logic [1:0] i_pin_dir_bit,
  output logic [1:0]      o_wave_out,
  output logic [1:0]      o_wave_oe,
  // Interrupt request and service
  input  wire logic [2:0] i_irq_ack,
  output logic [2:0]      o_irq_req
);

  // ==========================================================
  // Waveform output next state
  function automatic logic next_oc(input logic oc, input logic [1:0] act,
                                   input logic match, input logic bottom,
                                   input logic forced, input logic pwm,
                                   input logic fast, input logic up,
                                   input logic tog_ok);
    logic r;
    r = oc;
    if (!pwm) begin
      if (match || forced) begin
        if (act == ACT_TOGGLE) begin
          r = ~oc;
        end else if (act != ACT_NONE) begin
          r = act[0];
        end
      end
    end else if (act == ACT_TOGGLE) begin
      if (match && tog_ok) begin
        r = ~oc;
      end
    end else if (act[1]) begin
      // Bottom wins so a compare at max gives a steady level
      if (fast && bottom) begin
        r = ~act[0];
      end else if (match) begin
        r = (fast || up) ? act[0] : ~act[0];
      end
    end
    return r;
  endfunction : next_oc

  // ==========================================================
  // State
  logic [7:0] ctrl_a_r,  ctrl_a_nxt;
  logic [3:0] ctrl_b_r,  ctrl_b_nxt;
  logic [7:0] cnt_r,     cnt_nxt;
  logic       up_r,      up_nxt;
  logic       block_r,   block_nxt;
  logic [7:0] ocr_buf_r [2];
  logic [7:0] ocr_buf_nxt [2];
  logic [7:0] ocr_act_r [2];
  logic [7:0] ocr_act_nxt [2];
  logic [1:0] oc_r,      oc_nxt;
  logic [2:0] mask_r,    mask_nxt;
  logic [2:0] flag_r,    flag_nxt;
  logic [9:0] pre_r,     pre_nxt;
  logic [2:0] pin_sync_r;
  logic [1:0] wave_out_nxt;
  logic [2:0] irq_nxt;

  // Bus state
  axil_resp_t bus_r, bus_nxt;
  logic       wr_en, rd_en, wr_hit;
  logic [7:0] wdat;

  // Decode
  logic [2:0] wave_mode;
  logic [2:0] clock_select;
  logic       pwm, fast, ctc, tick, at_top, at_bottom, ov_evt;
  logic [7:0] top_val;
  logic [1:0] match, forced;
  logic [1:0] out_action [2];

  assign wave_mode     = {ctrl_b_r[CB_WAVE2], ctrl_a_r[1:0]};
  assign clock_select  = ctrl_b_r[2:0];
  assign out_action[0] = ctrl_a_r[CA_ACT_A_LSB +: 2];
  assign out_action[1] = ctrl_a_r[CA_ACT_B_LSB +: 2];
  assign pwm  = wave_mode[0];
  assign fast = wave_mode[1] & wave_mode[0];
  assign ctc  = (wave_mode == WM_CTC);
  assign top_val = wave_mode[2] ? ocr_act_r[0] : MAX_VAL;
  assign wdat = i_bus.wdata[7:0];
  assign wr_en = bus_r.awready;
  assign rd_en = bus_r.arready;
  assign wr_hit = wr_en && i_bus.wstrb[0];

  // ==========================================================
  // Timer tick select
  always_comb begin
    unique case (clock_select)
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1;
      3'h2: tick = ((pre_r & PRE_MASK_8) == PRE_MASK_8);
      3'h3: tick = ((pre_r & PRE_MASK_64) == PRE_MASK_64);
      3'h4: tick = ((pre_r & PRE_MASK_256) == PRE_MASK_256);
      3'h5: tick = (pre_r == PRE_MASK_1024);
      3'h6: tick = pin_sync_r[2] & ~pin_sync_r[1];
      3'h7: tick = ~pin_sync_r[2] & pin_sync_r[1];
    endcase
  end

  // ==========================================================
  // Counter, compare, flags and outputs
  always_comb begin
    cnt_nxt    = cnt_r;
    up_nxt     = up_r;
    block_nxt  = block_r;
    ctrl_a_nxt = ctrl_a_r;
    ctrl_b_nxt = ctrl_b_r;
    mask_nxt   = mask_r;
    pre_nxt    = pre_r + 10'h001;
    at_top     = 1'b0;
    at_bottom  = 1'b0;
    ov_evt     = 1'b0;
    forced     = 2'b00;
    for (int i = 0; i < 2; i++) begin
      ocr_buf_nxt[i] = ocr_buf_r[i];
      ocr_act_nxt[i] = ocr_act_r[i];
      // Equality is always watched, acted on only at a tick
      match[i] = tick && !block_r && (cnt_r == ocr_act_r[i]);
    end
    // Counting sequence per mode
    if (tick) begin
      block_nxt = 1'b0;
      if (pwm && !fast) begin
        if (up_r) begin
          if (cnt_r == top_val) begin
            up_nxt  = 1'b0;
            at_top  = 1'b1;
            cnt_nxt = cnt_r - 8'h01;
          end else begin
            cnt_nxt = cnt_r + 8'h01;
          end
        end else if (cnt_r == BOTTOM_VAL) begin
          up_nxt    = 1'b1;
          at_bottom = 1'b1;
          ov_evt    = 1'b1;
          cnt_nxt   = cnt_r + 8'h01;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end else if (fast) begin
        if (cnt_r == top_val) begin
          at_top    = 1'b1;
          at_bottom = 1'b1;
          ov_evt    = 1'b1;
          cnt_nxt   = BOTTOM_VAL;
        end else begin
          cnt_nxt = cnt_r + 8'h01;
        end
      end else begin
        up_nxt  = 1'b1;
        ov_evt  = (cnt_r == MAX_VAL);
        cnt_nxt = (ctc && cnt_r == ocr_act_r[0]) ? BOTTOM_VAL : cnt_r + 8'h01;
      end
    end
    // Buffered compare loads at the turning point only
    if (pwm && at_top) begin
      ocr_act_nxt[0] = ocr_buf_r[0];
      ocr_act_nxt[1] = ocr_buf_r[1];
    end
    // Software writes
    if (wr_hit) begin
      unique case (i_bus.awaddr)
        OFF_CONTROL_A: ctrl_a_nxt = wdat;
        OFF_CONTROL_B: begin
          ctrl_b_nxt = wdat[3:0];
          forced     = pwm ? 2'b00 : {wdat[CB_FORCE_B], wdat[CB_FORCE_A]};
        end
        OFF_COUNT: begin
          cnt_nxt   = wdat;
          block_nxt = 1'b1;
        end
        OFF_COMPARE_A, OFF_COMPARE_B: begin
          for (int i = 0; i < 2; i++) begin
            if (i_bus.awaddr == (i == 0 ? OFF_COMPARE_A : OFF_COMPARE_B)) begin
              ocr_buf_nxt[i] = wdat;
              if (!pwm) begin
                ocr_act_nxt[i] = wdat;
              end
            end
          end
        end
        OFF_IRQ_MASK: mask_nxt = wdat[2:0];
        default: ;
      endcase
    end
    // Flags: a same-cycle set beats any clear
    flag_nxt = flag_r & ~i_irq_ack;
    if (wr_hit && i_bus.awaddr == OFF_IRQ_FLAG) begin
      flag_nxt = flag_nxt & ~wdat[2:0];
    end
    flag_nxt = flag_nxt | {match, ov_evt};
    irq_nxt  = flag_nxt & mask_nxt;
    // Output state keeps its level across mode changes
    for (int i = 0; i < 2; i++) begin
      oc_nxt[i] = next_oc(oc_r[i], out_action[i], match[i], at_bottom,
                          forced[i], pwm, fast, up_r, i == 0 && wave_mode[2]);
      wave_out_nxt[i] = (out_action[i] != ACT_NONE) ? oc_nxt[i] : i_port_out[i];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ctrl_a_r   <= REG_RESET;
      ctrl_b_r   <= 4'h0;
      cnt_r      <= REG_RESET;
      up_r       <= 1'b1;
      block_r    <= 1'b0;
      ocr_buf_r  <= '{REG_RESET, REG_RESET};
      ocr_act_r  <= '{REG_RESET, REG_RESET};
      oc_r       <= 2'b00;
      mask_r     <= 3'h0;
      flag_r     <= 3'h0;
      pre_r      <= 10'h000;
      pin_sync_r <= 3'h0;
      o_wave_out <= 2'b00;
      o_wave_oe  <= 2'b00;
      o_irq_req  <= 3'h0;
    end else begin
      ctrl_a_r   <= ctrl_a_nxt;
      ctrl_b_r   <= ctrl_b_nxt;
      cnt_r      <= cnt_nxt;
      up_r       <= up_nxt;
      block_r    <= block_nxt;
      ocr_buf_r  <= ocr_buf_nxt;
      ocr_act_r  <= ocr_act_nxt;
      oc_r       <= oc_nxt;
      mask_r     <= mask_nxt;
      flag_r     <= flag_nxt;
      pre_r      <= pre_nxt;
      pin_sync_r <= {pin_sync_r[1:0], i_ext_count_pin};
      o_wave_out <= wave_out_nxt;
      o_wave_oe  <= i_pin_dir_bit;
      o_irq_req  <= irq_nxt;
    end
  end

  // ==========================================================
  // AXI4-Lite slave: one write and one read in flight
  always_comb begin
    bus_nxt = bus_r;
    // Address and data taken together, ready held one cycle
    bus_nxt.awready = i_bus.awvalid && i_bus.wvalid && !bus_r.awready && !bus_r.bvalid;
    bus_nxt.wready  = bus_nxt.awready;
    bus_nxt.arready = i_bus.arvalid && !bus_r.arready && !bus_r.rvalid;
    if (bus_r.bvalid && i_bus.bready) begin
      bus_nxt.bvalid = 1'b0;
    end
    if (wr_en) begin
      bus_nxt.bvalid = 1'b1;
      bus_nxt.bresp  = (i_bus.awaddr <= OFF_IRQ_FLAG && i_bus.awaddr[1:0] == 2'b00)
                       ? RESP_OKAY : RESP_SLVERR;
    end
    if (bus_r.rvalid && i_bus.rready) begin
      bus_nxt.rvalid = 1'b0;
    end
    if (rd_en) begin
      bus_nxt.rvalid = 1'b1;
      bus_nxt.rresp  = RESP_OKAY;
      bus_nxt.rdata  = 32'h0000_0000;
      unique case (i_bus.araddr)
        OFF_CONTROL_A: bus_nxt.rdata[7:0] = ctrl_a_r;
        OFF_CONTROL_B: bus_nxt.rdata[3:0] = ctrl_b_r;            // Strobes read zero
        OFF_COUNT:     bus_nxt.rdata[7:0] = cnt_r;
        OFF_COMPARE_A: bus_nxt.rdata[7:0] = pwm ? ocr_buf_r[0] : ocr_act_r[0];
        OFF_COMPARE_B: bus_nxt.rdata[7:0] = pwm ? ocr_buf_r[1] : ocr_act_r[1];
        OFF_IRQ_MASK:  bus_nxt.rdata[2:0] = mask_r;
        OFF_IRQ_FLAG:  bus_nxt.rdata[2:0] = flag_r;
        default:       bus_nxt.rresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      bus_r <= '0;
    end else begin
      bus_r <= bus_nxt;
    end
  end
  assign o_bus = bus_r;

  // ==========================================================
  // Checks
  stop_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (clock_select == 3'h0 && !wr_hit) |=> $stable(cnt_r))
    else $error("counter moved while stopped");
  cnt_write_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (wr_hit && i_bus.awaddr == OFF_COUNT) |=> cnt_r == $past(wdat))
    else $error("counter write lost to counting");
  flag_set_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    match[0] |=> flag_r[IRQ_A] ##1 (flag_r[IRQ_A] || $past(i_irq_ack[IRQ_A]) || $past(wr_hit)))
    else $error("compare flag not set after match");
  // Count write holds off every match until the next tick
  match_block_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (wr_hit && i_bus.awaddr == OFF_COUNT) |=> block_r && (match == 2'b00))
    else $error("match seen after counter write");
  block_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (block_r && !tick && !wr_hit) |=> block_r)
    else $error("match block dropped before a tick");
  wrap_ovf_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (tick && wave_mode == WM_NORMAL && cnt_r == MAX_VAL && !wr_hit)
    |=> (cnt_r == BOTTOM_VAL) && flag_r[IRQ_OV])
    else $error("normal wrap without overflow");
  oc_reset_a: assert property (@(posedge i_clk)
    !i_reset_n |=> oc_r == 2'b00)
    else $error("output state not cleared by reset");
  no_action_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (out_action[0] == ACT_NONE) |=> oc_r[0] == $past(oc_r[0]))
    else $error("output changed with no action");
  irq_mask_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ##1 o_irq_req == (flag_r & mask_r))
    else $error("request does not follow flags and mask");
  ack_clear_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_irq_ack[IRQ_OV] && !ov_evt) |=> !flag_r[IRQ_OV])
    else $error("serviced flag not cleared");
  buf_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (pwm && !at_top) |=> $stable(ocr_act_r[0]))
    else $error("buffered compare loaded off the turning point");
  port_over_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (out_action[1] != ACT_NONE) |=> o_wave_out[1] == oc_r[1])
    else $error("wave output not overriding port");
  oe_follow_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    1'b1 |=> o_wave_oe == $past(i_pin_dir_bit))
    else $error("pin direction not taken from port");
  force_quiet_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (forced[0] && !match[0]) |=> (!flag_r[IRQ_A] || $past(flag_r[IRQ_A])))
    else $error("forced compare set a flag");

endmodule : timer8_unit
`default_nettype wire

//--- dv/timer8_pin_model.sv
`default_nettype none
module timer8_pin_model (
  // Clock
  input  wire logic       i_clk,
  // Requests from the timer
  input  wire logic [2:0] i_irq_req,
  // Count pin and service acks
  output logic            o_ext_count_pin,
  output logic [2:0]      o_irq_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  int acks [3];
  int quiet;
  initial begin
    o_ext_count_pin = 1'b0;
    o_irq_ack = 3'h0;
    quiet = 0;
  end
  // ==========================================================
  // CPU side: one ack pulse per request, then a pause
  // Pause lets the registered request drop, avoiding a double ack
  always @(posedge i_clk) begin
    if (quiet > 0) begin
      o_irq_ack <= 3'h0;
      quiet--;
    end else if (|i_irq_req) begin
      o_irq_ack <= i_irq_req;
      quiet = 3;
      for (int k = 0; k < 3; k++) acks[k] += int'(i_irq_req[k]);
    end else begin
      o_irq_ack <= 3'h0;
    end
  end
  // ==========================================================
  // Pin pulses, each level held three cycles for clean sampling
  task automatic pulse(input int n);
    for (int i = 0; i < n; i++) begin
      o_ext_count_pin <= 1'b1;
      repeat (3) @(posedge i_clk);
      o_ext_count_pin <= 1'b0;
      repeat (3) @(posedge i_clk);
    end
  endtask : pulse
endmodule : timer8_pin_model
`default_nettype wire

//--- dv/timer8_unit_test.sv
`default_nettype none
module timer8_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  import timer8_pkg::*;
  logic        i_clk;
  logic        reset_n;
  axil_req_t   bus;
  axil_resp_t  resp;
  logic [1:0]  port_out;
  logic [1:0]  dir;
  logic [1:0]  wave_out;
  logic [1:0]  wave_oe;
  logic [2:0]  irq_ack;
  logic [2:0]  irq_req;
  logic        ext_pin;
  logic [31:0] rd;
  logic [1:0]  rr;
  int          mismatches;
  int          cmp_count;

  timer8_unit i_timer8_unit (
    .i_clk(i_clk), .i_reset_n(reset_n), .i_bus(bus), .o_bus(resp),
    .i_ext_count_pin(ext_pin), .i_port_out(port_out), .i_pin_dir_bit(dir),
    .o_wave_out(wave_out), .o_wave_oe(wave_oe), .i_irq_ack(irq_ack), .o_irq_req(irq_req)
  );
  timer8_pin_model i_timer8_pin_model (
    .i_clk(i_clk), .i_irq_req(irq_req), .o_ext_count_pin(ext_pin), .o_irq_ack(irq_ack)
  );

  // ==========================================================
  // Clock, 20 ns period
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic close_out;
    $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  // ==========================================================
  // Bus master; waits are bounded, the slave sets the pace
  // A hung handshake ends the run at once
  task automatic bus_hang;
    mismatches++;
    $display("CHECK FAILED at %0t: bus handshake never came", $time);
    close_out();
  endtask : bus_hang

  task automatic wait_bus(input int k);
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while ((k == 1 ? resp.bvalid : k == 2 ? resp.arready : resp.rvalid) !== 1'b1
               && n < 200);
    if (n >= 200) begin
      bus_hang();
    end
  endtask : wait_bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_done;
    logic w_done;
    int   n;
    aw_done = 1'b0;
    w_done  = 1'b0;
    n       = 0;
    @(posedge i_clk);
    bus.awaddr <= a;
    bus.wdata <= {24'h0, d};
    bus.wstrb <= 4'hf;
    bus.awvalid <= 1'b1;
    bus.wvalid <= 1'b1;
    bus.bready <= 1'b1;
    // Each channel drops at its own handshake edge
    while (!(aw_done && w_done)) begin
      @(posedge i_clk);
      n++;
      if (resp.awready === 1'b1 && !aw_done) begin
        aw_done = 1'b1;
        bus.awvalid <= 1'b0;
      end
      if (resp.wready === 1'b1 && !w_done) begin
        w_done = 1'b1;
        bus.wvalid <= 1'b0;
      end
      if (n >= 200) begin
        bus_hang();
      end
    end
    wait_bus(1);
    rr = resp.bresp;
    bus.bready <= 1'b0;
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    @(posedge i_clk);
    bus.araddr <= a;
    bus.arvalid <= 1'b1;
    bus.rready <= 1'b1;
    wait_bus(2);
    bus.arvalid <= 1'b0;
    wait_bus(3);
    rd = resp.rdata;
    rr = resp.rresp;
    bus.rready <= 1'b0;
  endtask : rd_reg

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
    rd_reg(a);
    chk(rd, e, m);
  endtask : rchk

  // Pin A output after two settling cycles
  task automatic pin_a(input logic e, input string m);
    repeat (2) @(posedge i_clk);
    chk(32'(wave_out[0]), 32'(e), m);
  endtask : pin_a

  // ==========================================================
  // Main sequence
  initial begin
    bus = '0;
    port_out = 2'b11;
    dir = 2'b01;
    reset_n = 1'b0;
    repeat (6) @(posedge i_clk);
    reset_n <= 1'b1;
    // Register reset values, unmapped and unaligned refusals
    for (int a = 0; a <= 24; a += 4) rchk(8'(a), 32'h0, "reset value");
    rd_reg(8'h1c);
    chk(32'(rr), 32'(RESP_SLVERR), "unmapped read");
    wr(8'h09, 8'h12);
    chk(32'(rr), 32'(RESP_SLVERR), "unaligned write");
    rchk(OFF_COUNT, 32'h0, "unaligned write had effect");
    chk({28'h0, wave_out, wave_oe}, 32'hd, "port pass and direction");
    dir <= 2'b10;
    repeat (2) @(posedge i_clk);
    chk(32'(wave_oe), 32'h2, "direction not followed");
    // Output state: reset, force, mode change, action zero, new action
    wr(OFF_CONTROL_A, 8'h40);
    pin_a(1'b0, "state after reset");
    wr(OFF_CONTROL_B, 8'h80);
    pin_a(1'b1, "force toggle");
    rchk(OFF_IRQ_FLAG, 32'h0, "force set a flag");
    wr(OFF_CONTROL_A, 8'h41);
    wr(OFF_CONTROL_A, 8'h40);
    pin_a(1'b1, "state lost on mode change");
    wr(OFF_CONTROL_A, 8'h00);
    wr(OFF_CONTROL_B, 8'h80);
    wr(OFF_CONTROL_A, 8'h40);
    pin_a(1'b1, "action zero changed state");
    wr(OFF_CONTROL_A, 8'h80);
    wr(OFF_CONTROL_B, 8'h80);
    pin_a(1'b0, "new action ignored");
    // Count write equal to compare blocks the first match
    wr(OFF_CONTROL_A, 8'h40);
    wr(OFF_COMPARE_A, 8'h10);
    wr(OFF_COUNT, 8'h10);
    wr(OFF_CONTROL_B, 8'h01);
    repeat (10) @(posedge i_clk);
    rchk(OFF_IRQ_FLAG, 32'h0, "blocked match flagged");
    pin_a(1'b0, "blocked match toggled");
    wr(OFF_COUNT, 8'h0e);
    repeat (10) @(posedge i_clk);
    rchk(OFF_IRQ_FLAG, 32'h2, "match flag A");
    pin_a(1'b1, "match toggle");
    wr(OFF_IRQ_FLAG, 8'h02);
    rchk(OFF_IRQ_FLAG, 32'h0, "write one clear");
    // Overflow at wrap, then serviced interrupts
    // Park both compares away from the wrap and the later windows
    wr(OFF_COMPARE_A, 8'h80);
    wr(OFF_COMPARE_B, 8'h80);
    wr(OFF_COUNT, 8'hfc);
    repeat (6) @(posedge i_clk);
    rchk(OFF_IRQ_FLAG, 32'h1, "overflow at wrap");
    wr(OFF_IRQ_MASK, 8'h01);
    repeat (5) @(posedge i_clk);
    chk(32'(i_timer8_pin_model.acks[0]), 32'h1, "overflow request");
    rchk(OFF_IRQ_FLAG, 32'h0, "service clear");
    wr(OFF_IRQ_MASK, 8'h04);
    wr(OFF_COMPARE_B, 8'h30);
    wr(OFF_COUNT, 8'h2e);
    repeat (8) @(posedge i_clk);
    chk(32'(i_timer8_pin_model.acks[2]), 32'h1, "match B request");
    chk(32'(i_timer8_pin_model.acks[1]), 32'h0, "masked A request");
    // Clear on compare: count stays within compare A
    wr(OFF_CONTROL_B, 8'h00);
    wr(OFF_CONTROL_A, 8'h12);
    wr(OFF_COMPARE_A, 8'h05);
    wr(OFF_COUNT, 8'h00);
    wr(OFF_CONTROL_B, 8'h01);
    for (int i = 0; i < 6; i++) begin
      rd_reg(OFF_COUNT);
      chk(32'(rd <= 32'h5), 32'h1, "count above top");
    end
    // Channel B state never moved, so the pin must leave the port level
    chk(32'(wave_out[1]), 32'h0, "port not overridden by B");
    // Fast PWM buffering of compare A
    wr(OFF_CONTROL_B, 8'h00);
    wr(OFF_CONTROL_A, 8'h03);
    wr(OFF_COMPARE_A, 8'h20);
    rchk(OFF_COMPARE_A, 32'h20, "buffer read");
    wr(OFF_CONTROL_A, 8'h00);
    rchk(OFF_COMPARE_A, 32'h5, "active changed early");
    wr(OFF_CONTROL_A, 8'h03);
    wr(OFF_CONTROL_B, 8'h01);
    repeat (300) @(posedge i_clk);
    wr(OFF_CONTROL_B, 8'h00);
    wr(OFF_CONTROL_A, 8'h00);
    rchk(OFF_COMPARE_A, 32'h20, "buffer not loaded at top");
    // Divide by eight for about 84 cycles
    wr(OFF_COUNT, 8'h00);
    wr(OFF_CONTROL_B, 8'h02);
    repeat (80) @(posedge i_clk);
    wr(OFF_CONTROL_B, 8'h00);
    rd_reg(OFF_COUNT);
    chk(32'(rd >= 32'h9 && rd <= 32'hb), 32'h1, "prescaled count");
    // Pin edges: rising with select 7, falling with 6
    for (int e = 0; e < 2; e++) begin
      wr(OFF_COUNT, 8'h00);
      wr(OFF_CONTROL_B, 8'(7 - e));
      i_timer8_pin_model.pulse(5);
      repeat (6) @(posedge i_clk);
      rchk(OFF_COUNT, 32'h5, "pin edge count");
    end
    // Stopped counter keeps the written value
    wr(OFF_CONTROL_B, 8'h00);
    wr(OFF_COUNT, 8'h55);
    repeat (20) @(posedge i_clk);
    rchk(OFF_COUNT, 32'h55, "stopped count moved");
    close_out();
  end

  // ==========================================================
  // Watchdog, well beyond the roughly 830 cycles needed
  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    close_out();
  end
endmodule : timer8_unit_test
`default_nettype wire
